// File: dual_timebase_capture_timer.sv
`timescale 1ns/100ps
// Two 8-bit timebases and an input capture, reached over APB
module dual_timebase_capture_timer
   import timebase_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capturePin,
   input wire logic haltMode,
   output logic irqTimebase1,
   output logic irqTimebase2,
   output logic irqCapture
);

   // Software-visible state
   logic captureIrqEnable;
   logic captureFlag;
   logic periodSelect;
   logic firstTimebaseIrqEnable;
   logic firstTimebaseFlag;
   logic secondTimebaseIrqEnable;
   logic secondTimebaseFlag;
   logic [7:0] reloadValue;
   logic [7:0] countValue;
   logic [7:0] capturedCount;

   // Hidden timebase 1 state
   logic [7:0] firstCount;
   logic halfPhase;

   // Event pulses
   logic tick;
   logic firstStep;
   logic firstOverflow;
   logic secondOverflow;
   logic pinEdge;
   logic captureNow;

   // Bus decode
   apb_state_t apbState;
   logic accessDone;
   logic writeDone;
   logic readDone;
   logic hitCsr2;
   logic hitReload;
   logic hitCount;
   logic hitCsr1;
   logic hitCapture;
   logic mapped;
   logic [7:0] readByte;

   // Flags that the pending read has shown as set
   logic clearFirstFlag;
   logic clearSecondFlag;
   logic clearCaptureFlag;

   // Halt freezes the divider, which freezes both counters
   tick_divider u_tick_divider (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .run(!haltMode),
      .tick(tick)
   );

   edge_sync u_edge_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pinIn(capturePin),
      .edgeSeen(pinEdge)
   );

   // ------------------------------------------------------------
   // Timebase 1
   // ------------------------------------------------------------

   // Period select 1 skips every other tick, doubling 8000 to 16000
   assign firstStep = tick && (!periodSelect || halfPhase);
   assign firstOverflow = firstStep
                          && (firstCount == TB1_WRAP_VALUE);

   // Phase of the halving divider used by the long period
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         halfPhase <= 1'b0;
      end else if (tick) begin
         halfPhase <= !halfPhase;
      end
   end

   // Counter 1 runs from zero and is never seen by software
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         firstCount <= RESET_COUNT;
      end else if (firstStep) begin
         if (firstCount == TB1_WRAP_VALUE) begin
            firstCount <= RESET_COUNT;
         end else begin
            firstCount <= firstCount + 8'h01;
         end
      end
   end

   // Timebase 1 flag: a new overflow wins over the read clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         firstTimebaseFlag <= 1'b0;
      end else if (firstOverflow) begin
         firstTimebaseFlag <= 1'b1;
      end else if (readDone && clearFirstFlag) begin
         firstTimebaseFlag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------

   // Edges are dropped while an unread capture is pending
   assign captureNow = pinEdge && !captureFlag;

   // Capture register holds the last latched counter 1 value
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         capturedCount <= RESET_CAPTURE_VALUE;
      end else if (captureNow) begin
         capturedCount <= firstCount;
      end
   end

   // Capture flag is given a defined zero at reset, which also
   // satisfies the read software performs after reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         captureFlag <= 1'b0;
      end else if (captureNow) begin
         captureFlag <= 1'b1;
      end else if (readDone && clearCaptureFlag) begin
         captureFlag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Timebase 2
   // ------------------------------------------------------------

   assign secondOverflow = tick && (countValue == TB2_TOP_VALUE);

   // Counter 2 starts from the reload reset value and reloads on
   // overflow; reload writes only matter at the next overflow
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         countValue <= RESET_TB2_RELOAD;
      end else if (secondOverflow) begin
         countValue <= reloadValue;
      end else if (tick) begin
         countValue <= countValue + 8'h01;
      end
   end

   // Timebase 2 flag: set wins over the read clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         secondTimebaseFlag <= 1'b0;
      end else if (secondOverflow) begin
         secondTimebaseFlag <= 1'b1;
      end else if (readDone && clearSecondFlag) begin
         secondTimebaseFlag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------

   assign hitCsr2 = (paddr == regAddr(IDX_TB2_CTRL_STATUS));
   assign hitReload = (paddr == regAddr(IDX_TB2_RELOAD));
   assign hitCount = (paddr == regAddr(IDX_TB2_COUNT));
   assign hitCsr1 = (paddr == regAddr(IDX_TB1_CAP_CTRL_STATUS));
   assign hitCapture = (paddr == regAddr(IDX_CAPTURE_VALUE));
   assign mapped = hitCsr2 || hitReload || hitCount || hitCsr1
                   || hitCapture;

   // The answer edge: request held with pready high
   assign accessDone = psel && penable && pready;
   assign writeDone = accessDone && pwrite && mapped;
   assign readDone = accessDone && !pwrite && mapped;

   // Read data mux; reserved bits read as zero
   always_comb begin
      readByte = 8'h00;
      if (hitCsr2) begin
         readByte[TB2_IRQ_ENABLE_BIT] = secondTimebaseIrqEnable;
         readByte[TB2_FLAG_BIT] = secondTimebaseFlag;
      end else if (hitReload) begin
         readByte = reloadValue;
      end else if (hitCount) begin
         readByte = countValue;
      end else if (hitCsr1) begin
         readByte[CAP_IRQ_ENABLE_BIT] = captureIrqEnable;
         readByte[CAP_FLAG_BIT] = captureFlag;
         readByte[PERIOD_SELECT_BIT] = periodSelect;
         readByte[TB1_IRQ_ENABLE_BIT] = firstTimebaseIrqEnable;
         readByte[TB1_FLAG_BIT] = firstTimebaseFlag;
      end else if (hitCapture) begin
         readByte = capturedCount;
      end
   end

   // One wait state so that read data can come from a register
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         apbState <= APB_IDLE;
      end else begin
         unique case (apbState)
            APB_IDLE: begin
               if (psel && penable) begin
                  apbState <= APB_ANSWER;
               end
            end
            APB_ANSWER: begin
               apbState <= APB_IDLE;
            end
         endcase
      end
   end

   // Ready is high for exactly the cycle after the first access cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pready <= 1'b0;
      end else begin
         pready <= (apbState == APB_IDLE) && psel && penable;
      end
   end

   // Read data and error are sampled one edge before the answer
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if ((apbState == APB_IDLE) && psel && penable) begin
         prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, readByte};
         pslverr <= !mapped || (paddr[1:0] != 2'b00);
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Only flags the snapshot saw as set get cleared, so a timebase event
   // landing between snapshot and answer is never lost; a pin edge there is dropped if the snapshot saw the capture flag set
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         clearFirstFlag <= 1'b0;
         clearSecondFlag <= 1'b0;
         clearCaptureFlag <= 1'b0;
      end else if ((apbState == APB_IDLE) && psel && penable) begin
         clearFirstFlag <= !pwrite && hitCsr1 && firstTimebaseFlag;
         clearSecondFlag <= !pwrite && hitCsr2
                            && secondTimebaseFlag;
         clearCaptureFlag <= !pwrite && hitCapture
                             && captureFlag;
      end
   end

   // First control/status writes; flag positions are not writable
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         captureIrqEnable <= RESET_TB1_CAP_CTRL_STATUS[CAP_IRQ_ENABLE_BIT];
         periodSelect <= RESET_TB1_CAP_CTRL_STATUS[PERIOD_SELECT_BIT];
         firstTimebaseIrqEnable <=
            RESET_TB1_CAP_CTRL_STATUS[TB1_IRQ_ENABLE_BIT];
      end else if (writeDone && hitCsr1) begin
         captureIrqEnable <= pwdata[CAP_IRQ_ENABLE_BIT];
         periodSelect <= pwdata[PERIOD_SELECT_BIT];
         firstTimebaseIrqEnable <= pwdata[TB1_IRQ_ENABLE_BIT];
      end
   end

   // Second control/status writes; reserved bits are discarded
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         secondTimebaseIrqEnable <=
            RESET_TB2_CTRL_STATUS[TB2_IRQ_ENABLE_BIT];
      end else if (writeDone && hitCsr2) begin
         secondTimebaseIrqEnable <= pwdata[TB2_IRQ_ENABLE_BIT];
      end
   end

   // Reload register accepts writes at any time
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reloadValue <= RESET_TB2_RELOAD;
      end else if (writeDone && hitReload) begin
         reloadValue <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // Interrupt requests, registered, one cycle behind the flags
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irqTimebase1 <= 1'b0;
         irqTimebase2 <= 1'b0;
         irqCapture <= 1'b0;
      end else begin
         irqTimebase1 <= firstTimebaseFlag
                         && firstTimebaseIrqEnable;
         irqTimebase2 <= secondTimebaseFlag
                         && secondTimebaseIrqEnable;
         irqCapture <= captureFlag && captureIrqEnable;
      end
   end

endmodule // dual_timebase_capture_timer

// File: timebase_timer_pkg.sv
// Notes on behaviour
// - Timebase 1 counter starts at zero, steps each oscillator/32 tick (every other tick with period select 1), hidden from software.
// - Timebase 1 overflows on the F9h to 00h rollover, a 250-step cycle.
// - Period select 0 gives 8000 oscillator periods, 1 gives 16000.
// - Timebase 1 overflow sets its flag; interrupt requested while its enable is set.
// - Reading first control/status clears timebase 1 flag; writes to it do nothing.
// - Any capture pin edge copies counter 1 into capture register, sets capture flag.
// - Capture interrupt requested while capture flag and capture enable are both set.
// - Only a read of the capture register clears the capture flag; writes do nothing.
// - While capture flag is set, pin edges are ignored and capture value holds.
// - Capture register is read-only, zero after reset, holds the latest capture.
// - Counter 2 starts from reload value, steps each oscillator/32 tick, readable.
// - Counter 2 overflows past FFh and reloads from the reload register.
// - Reload writes are allowed anytime and take effect at the next overflow.
// - Counter 2 overflow sets its flag and interrupt; read clears, writes ignored.
// - Both counters stop in Halt; Slow, Wait and Active Halt do not matter.
// - Three separate interrupt outputs, each gated by its own enable bit.
// - First control/status: 7 cap enable, 6 cap flag, 5 period, 4 tb1 en, 3 tb1 flag.
// - Second control/status: bit 1 tb2 enable, bit 0 tb2 flag, bits 7:2 zero.
package timebase_timer_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TB2_CTRL_STATUS = 8'h0C;
   localparam logic [7:0] IDX_TB2_RELOAD = 8'h0D;
   localparam logic [7:0] IDX_TB2_COUNT = 8'h0E;
   localparam logic [7:0] IDX_TB1_CAP_CTRL_STATUS = 8'h0F;
   localparam logic [7:0] IDX_CAPTURE_VALUE = 8'h10;

   // First control/status field positions
   localparam int CAP_IRQ_ENABLE_BIT = 7;
   localparam int CAP_FLAG_BIT = 6;
   localparam int PERIOD_SELECT_BIT = 5;
   localparam int TB1_IRQ_ENABLE_BIT = 4;
   localparam int TB1_FLAG_BIT = 3;

   // Second control/status field positions
   localparam int TB2_IRQ_ENABLE_BIT = 1;
   localparam int TB2_FLAG_BIT = 0;

   // Reset values
   localparam logic [7:0] RESET_TB2_CTRL_STATUS = 8'h00;
   localparam logic [7:0] RESET_TB2_RELOAD = 8'h00;
   localparam logic [7:0] RESET_TB1_CAP_CTRL_STATUS = 8'h00;
   localparam logic [7:0] RESET_CAPTURE_VALUE = 8'h00;
   localparam logic [7:0] RESET_COUNT = 8'h00;

   // Counting constants
   localparam int OSC_PER_TICK = 32;
   localparam logic [4:0] TICK_LAST = 5'(OSC_PER_TICK - 1);
   localparam logic [7:0] TB1_WRAP_VALUE = 8'hF9;
   localparam logic [7:0] TB2_TOP_VALUE = 8'hFF;
   localparam logic [1:0] SYNC_ARM_CYCLES = 2'h2;

   // APB slave phases
   typedef enum logic {
      APB_IDLE,
      APB_ANSWER
   } apb_state_t;

   // Byte address of a register index
   function automatic logic [7:0] regAddr(input logic [7:0] idx);
      regAddr = {idx[5:0], 2'b00};
   endfunction

endpackage

// File: tick_divider.sv
`timescale 1ns/100ps
// Divides the oscillator down to one-cycle tick enables
module tick_divider
   import timebase_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic run,
   output logic tick
);

   logic [4:0] divCount;

   // Free count of oscillator periods; frozen while not running
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         divCount <= 5'h00;
      end else if (run) begin
         divCount <= (divCount == TICK_LAST) ? 5'h00 : divCount + 5'h01;
      end
   end

   // Tick is combinational so it lines up with the last divider cycle
   assign tick = run && (divCount == TICK_LAST);

endmodule // tick_divider

// File: edge_sync.sv
`timescale 1ns/100ps
// Brings the capture pin into the clock domain and flags its edges
module edge_sync
   import timebase_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic pinIn,
   output logic edgeSeen
);

   logic syncFirst;
   logic syncSecond;
   logic syncPrev;
   logic [1:0] armCount;

   // Two-stage synchroniser, then one more stage for comparison
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         syncFirst <= 1'b0;
         syncSecond <= 1'b0;
         syncPrev <= 1'b0;
      end else begin
         syncFirst <= pinIn;
         syncSecond <= syncFirst;
         syncPrev <= syncSecond;
      end
   end

   // Edges are masked for two cycles after reset, too short to hide a pin already high at reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         armCount <= 2'h0;
      end else if (armCount != SYNC_ARM_CYCLES) begin
         armCount <= armCount + 2'h1;
      end
   end

   assign edgeSeen = (armCount == SYNC_ARM_CYCLES)
                     && (syncSecond != syncPrev);

endmodule // edge_sync

// File: dual_timebase_capture_timer_asserts.sv
`timescale 1ns/100ps
// Pin-level checks of the APB answer and of the three request lines
module dual_timebase_capture_timer_asserts
   import timebase_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic capturePin,
   input wire logic haltMode,
   input wire logic irqTimebase1,
   input wire logic irqTimebase2,
   input wire logic irqCapture
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   // Completed accesses; a request line may only drop after one of these
   logic doneCsr1;
   logic doneCsr2;
   logic doneCap;
   logic rdCsr1;
   logic rdCsr2;
   assign doneCsr1 = psel && penable && pready && paddr == 8'h3C;
   assign doneCsr2 = psel && penable && pready && paddr == 8'h30;
   assign doneCap = psel && penable && pready && paddr == 8'h40;
   assign rdCsr1 = doneCsr1 && !pwrite;
   assign rdCsr2 = doneCsr2 && !pwrite;
   // Access phase, then a single-cycle answer
   sequence waitState;
      psel && penable && !pready;
   endsequence
   sequence onePulse;
      pready ##1 !pready;
   endsequence
   a_one_wait: assert property (waitState |=> onePulse)
      else $error("Answer not a pulse after one wait state");
   a_idle_quiet: assert property (!(psel && penable) |=> !pready)
      else $error("Answer without an access");
   a_csr1_reserved: assert property (
      rdCsr1 |-> prdata[2:0] == 3'h0)
      else $error("Low bits of first status not zero");
   a_csr2_reserved: assert property (
      rdCsr2 |-> prdata[7:2] == 6'h00)
      else $error("Upper bits of second status not zero");
   a_tb1_clear: assert property (
      $fell(irqTimebase1) |-> $past(doneCsr1, 2))
      else $error("First timebase request dropped on its own");
   a_tb2_clear: assert property (
      $fell(irqTimebase2) |-> $past(doneCsr2, 2))
      else $error("Second timebase request dropped on its own");
   a_cap_clear: assert property (
      $fell(irqCapture) |-> $past(doneCap, 2) || $past(doneCsr1, 2))
      else $error("Capture request dropped on its own");
   a_irq1_gated: assert property (
      rdCsr1 |-> (prdata[7] || !irqCapture) && (prdata[4] || !irqTimebase1))
      else $error("Request high with its enable clear");
   a_irq2_gated: assert property (
      rdCsr2 |-> prdata[1] || !irqTimebase2)
      else $error("Second request high with its enable clear");
   // Reset is synchronous, so outputs are quiet one edge later
   a_reset_quiet: assert property (disable iff (1'b0)
      !reset_n |=> !pready && !irqCapture && !irqTimebase1 && !irqTimebase2)
      else $error("Outputs active after a reset edge");
endmodule // dual_timebase_capture_timer_asserts

bind dual_timebase_capture_timer dual_timebase_capture_timer_asserts u_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .capturePin(capturePin),
   .haltMode(haltMode), .irqTimebase1(irqTimebase1),
   .irqTimebase2(irqTimebase2), .irqCapture(irqCapture)
);

// File: capture_source.sv
`timescale 1ns/100ps
// Far-side edge source; each flip request gives one clean pin edge
module capture_source (
   input wire logic ref_clk,
   input wire logic flip,
   output logic pin
);
   initial pin = 1'b0;
   // Edges follow the clock, so the pin holds a full cycle each way
   always @(posedge ref_clk) begin
      if (flip) begin
         pin <= ~pin;
      end
   end
endmodule // capture_source

// File: dual_timebase_capture_timer_bench.sv
`timescale 1ns/100ps
// Register-level bench for the dual timebase and capture timer
module dual_timebase_capture_timer_bench;
   import timebase_timer_pkg::*;
   localparam logic [7:0] A_CSR2 = IDX_TB2_CTRL_STATUS << 2;
   localparam logic [7:0] A_RLD = IDX_TB2_RELOAD << 2;
   localparam logic [7:0] A_CNT = IDX_TB2_COUNT << 2;
   localparam logic [7:0] A_CSR1 = IDX_TB1_CAP_CTRL_STATUS << 2;
   localparam logic [7:0] A_CAP = IDX_CAPTURE_VALUE << 2;
   logic ref_clk = 1'b0, reset_n = 1'b0, flip = 1'b0, haltMode = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, keep;
   logic pready, pslverr, capturePin, lastErr;
   logic [2:0] irqVec;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0, t1, t2, t3, u0, u1;

   dual_timebase_capture_timer u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capturePin(capturePin), .haltMode(haltMode),
      .irqTimebase1(irqVec[0]), .irqTimebase2(irqVec[1]),
      .irqCapture(irqVec[2])
   );
   capture_source u_src (.ref_clk(ref_clk), .flip(flip), .pin(capturePin));

   // Clock and a cycle count used to time overflows
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
   end

   task automatic stop_test();
      if (err_total == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask

   // One APB transfer; the answer is sampled at the edge pready is seen
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_total++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd, {24'h0, e});
   endtask

   // Bounded wait for a fresh rise of a request line; a line that is
   // still high from a flag just read clear must drop first
   task automatic wait_irq(input int k, output int at);
      int n;
      n = 0;
      while (irqVec[k] === 1'b1 && n < 20000) begin
         @(posedge ref_clk);
         n++;
      end
      do begin
         @(posedge ref_clk);
         n++;
      end while (irqVec[k] !== 1'b1 && n < 20000);
      at = cyc;
      if (n >= 20000) begin
         err_total++;
         stop_test();
      end
   endtask

   // Pin edge at a fixed distance from the last first-timebase event
   task automatic flip_at(input int m);
      while (cyc < t1 + m) begin
         @(posedge ref_clk);
      end
      flip <= 1'b1;
      @(posedge ref_clk);
      flip <= 1'b0;
   endtask

   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Reset values; the capture read also settles its flag
      rdchk(A_CNT, 8'h00);
      rdchk(A_CAP, 8'h00);
      rdchk(A_CSR1, 8'h00);
      rdchk(A_CSR2, 8'h00);
      rdchk(A_RLD, 8'h00);
      // Holes and misaligned addresses are refused
      xfer(1'b0, 8'h44, 32'h0);
      chk({31'h0, lastErr}, 32'h1);
      xfer(1'b1, 8'h31, 32'hFF);
      chk({31'h0, lastErr}, 32'h1);
      // Writable fields only; flags and the capture value ignore writes
      wr(A_CAP, 8'hFF);
      rdchk(A_CAP, 8'h00);
      wr(A_CSR1, 8'hFF);
      rdchk(A_CSR1, 8'hB0);
      wr(A_CSR2, 8'hFF);
      rdchk(A_CSR2, 8'h02);
      wr(A_RLD, 8'hA5);
      rdchk(A_RLD, 8'hA5);
      wr(A_CSR1, 8'h90);
      // Counting freezes while halted
      haltMode <= 1'b1;
      xfer(1'b0, A_CNT, 32'h0);
      keep = rd;
      repeat (100) @(posedge ref_clk);
      rdchk(A_CNT, keep[7:0]);
      haltMode <= 1'b0;
      // First timebase event and its clear on read
      wait_irq(0, t0);
      rdchk(A_CSR1, 8'h98);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irqVec[0]}, 32'h0);
      // Second counter reloads; a new reload waits for the next overflow
      wait_irq(1, u0);
      rdchk(A_CNT, 8'hA5);
      wr(A_RLD, 8'hF0);
      rdchk(A_CNT, 8'hA5);
      rdchk(A_CSR2, 8'h03);
      wait_irq(1, u1);
      chk(32'(u1 - u0), 32'hB60);
      rdchk(A_CNT, 8'hF0);
      wait_irq(0, t1);
      chk(32'(t1 - t0), 32'h1F40);
      rdchk(A_CSR1, 8'h98);
      // Rising edge captured, falling edge captured, third edge lost
      flip_at(522);
      repeat (6) @(posedge ref_clk);
      chk({31'h0, irqVec[2]}, 32'h1);
      rdchk(A_CAP, 8'h10);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irqVec[2]}, 32'h0);
      flip_at(1130);
      flip_at(1300);
      rdchk(A_CAP, 8'h23);
      // Doubled period; timed from the first event after the switch to the next
      wr(A_CSR1, 8'hB0);
      wait_irq(0, t2);
      rdchk(A_CSR1, 8'hB8);
      wait_irq(0, t3);
      chk(32'(t3 - t2), 32'h3E80);
      stop_test();
   end
endmodule // dual_timebase_capture_timer_bench
